/* File: core/fpl_ctrl.sv */
/*
 * Front-panel status controller: power LED patterns, system fault LED,
 * supply-on supervision, power-good interrupts and switch outputs, with an
 * APB register slave.
 * Assumes inputs synchronous to pclk; LED and switch pins are active low.
 */
// The APB register port and the register addresses were chosen for this implementation.
// Overview of operation
// - All LED drive outputs are active low: low lights the LED.
// - Power LED offers off, solid, slow blink and fast blink.
// - On with standby and good: solid; good missing: fast blink; else dark.
// - Sleep with standby, good and supply-on request: slow blink.
// - Compare power-good against the commanded supply-on request.
// - Request on but power-good missing: light the system fault LED.
// - Keep waiting; on power-good clear fault, then release system reset.
// - Power-good change interrupts; on AC loss assert system reset at once.
// - System fault LED shows power fault or fan failure only.
// - Switch outputs are open collector, true when low.
`timescale 1ns/1ps
`default_nettype none
`include "fpl_consts.svh"

module fpl_ctrl #(
	parameter int unsigned SLOW_HALF_CYC = `FPL_SLOW_HALF_CYC,
	parameter int unsigned FAST_HALF_CYC = `FPL_FAST_HALF_CYC,
	parameter int unsigned GOOD_WAIT_CYC = `FPL_GOOD_WAIT_CYC
) (
	// Clock and reset.
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	// Supply signals.
	input  wire logic        standby_present,
	input  wire logic        supply_good_input,
	output var  logic        supply_on_request,
	// System control.
	output var  logic        system_reset,
	output var  logic        irq,
	// Front-panel LEDs, active low.
	output var  logic        power_led_n,
	output var  logic        system_fault_indicator_n,
	// Switch outputs, open collector, true when low.
	output var  logic        sw_power_o,
	output var  logic        sw_power_oe,
	output var  logic        sw_sleep_o,
	output var  logic        sw_sleep_oe,
	output var  logic        sw_reset_o,
	output var  logic        sw_reset_oe,
	output var  logic        sw_nmi_o,
	output var  logic        sw_nmi_oe
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [7:0]                 ctrl_r, ctrl_nxt;
	logic [`FPL_IRQ_WIDTH-1:0]  ist_r, ist_nxt;
	logic [`FPL_IRQ_WIDTH-1:0]  imask_r, imask_nxt;
	logic [31:0]                prdata_r, prdata_nxt;
	logic                       pready_r, pready_nxt;
	logic                       pslverr_r, pslverr_nxt;
	logic                       good_d_r, stby_d_r;
	fpl_pkg::fpl_sup_e          sup_r, sup_nxt;
	logic [31:0]                wait_r, wait_nxt;
	logic                       pfault_r, pfault_nxt;
	logic                       sysrst_r, sysrst_nxt;
	fpl_pkg::fpl_led_e          pat;
	fpl_pkg::fpl_pstate_e       pst;
	logic                       pled_r, pled_nxt;
	logic                       pled_n_r, fled_n_r;
	logic                       irq_r;
	logic [3:0]                 sw_r;
	logic                       slow_ph, fast_ph;
	logic                       wr_acc, rd_acc, addr_ok;
	logic                       good_chg, ac_loss;
	logic [`FPL_IRQ_WIDTH-1:0]  ev;

	// Decode one register offset against the bus address.
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		hit = (a == ofs);
	endfunction

	// ****************************************************************
	// Blink dividers
	// ****************************************************************

	// Free-running dividers give the slow and fast blink phases.
	fpl_blink #(.HALF_CYC(SLOW_HALF_CYC)) u_slow (
		.pclk    (pclk),
		.presetn (presetn),
		.phase   (slow_ph)
	);
	fpl_blink #(.HALF_CYC(FAST_HALF_CYC)) u_fast (
		.pclk    (pclk),
		.presetn (presetn),
		.phase   (fast_ph)
	);

	// ****************************************************************
	// APB slave
	// ****************************************************************
	assign addr_ok = hit(paddr, `FPL_OFS_CTRL) | hit(paddr, `FPL_OFS_STATUS) |
	                 hit(paddr, `FPL_OFS_IRQ_STAT) | hit(paddr, `FPL_OFS_IRQ_MASK) |
	                 hit(paddr, `FPL_OFS_INPUTS);
	// Writes land at the edge that completes the transfer, where pready is seen high.
	assign wr_acc  = psel & penable & pwrite & pready_r;
	assign rd_acc  = psel & penable & ~pwrite & ~pready_r;

	// Edge events from the supply inputs.
	assign good_chg = supply_good_input ^ good_d_r;
	assign ac_loss  = good_d_r & ~supply_good_input & ctrl_r[`FPL_CTRL_SUPPLY_ON];
	assign ev       = {sup_r == fpl_pkg::FPL_SUP_WAIT && sup_nxt == fpl_pkg::FPL_SUP_FAULT,
	                   ac_loss, good_chg};

	// Register writes, sticky status with set winning over clear, read mux.
	always_comb begin
		ctrl_nxt    = ctrl_r;
		imask_nxt   = imask_r;
		ist_nxt     = ist_r;
		prdata_nxt  = 32'h0;
		pready_nxt  = psel & penable & ~pready_r;
		pslverr_nxt = psel & penable & ~pready_r & ~addr_ok;
		if (wr_acc && hit(paddr, `FPL_OFS_CTRL)) begin
			ctrl_nxt = pwdata[7:0];
		end
		if (wr_acc && hit(paddr, `FPL_OFS_IRQ_MASK)) begin
			imask_nxt = pwdata[`FPL_IRQ_WIDTH-1:0];
		end
		if (wr_acc && hit(paddr, `FPL_OFS_IRQ_STAT)) begin
			ist_nxt = ist_r & ~pwdata[`FPL_IRQ_WIDTH-1:0];
		end
		ist_nxt = ist_nxt | ev;
		if (rd_acc) begin
			case (1'b1)
				hit(paddr, `FPL_OFS_CTRL):     prdata_nxt = {24'h0, ctrl_r};
				hit(paddr, `FPL_OFS_STATUS):   prdata_nxt = {27'h0, sysrst_r, pfault_r,
				                                             pled_r, pat};
				hit(paddr, `FPL_OFS_IRQ_STAT): prdata_nxt = {29'h0, ist_r};
				hit(paddr, `FPL_OFS_IRQ_MASK): prdata_nxt = {29'h0, imask_r};
				hit(paddr, `FPL_OFS_INPUTS):   prdata_nxt = {30'h0, supply_good_input,
				                                             standby_present};
				default:                       prdata_nxt = 32'h0;
			endcase
		end
	end

	// ****************************************************************
	// Supply-on supervision
	// ****************************************************************

	// Watch power-good against the commanded request; flag and recover faults.
	always_comb begin
		sup_nxt    = sup_r;
		wait_nxt   = wait_r;
		pfault_nxt = pfault_r;
		sysrst_nxt = sysrst_r;
		case (sup_r)
			fpl_pkg::FPL_SUP_IDLE: begin
				sysrst_nxt = 1'b1;
				if (ctrl_r[`FPL_CTRL_SUPPLY_ON]) begin
					sup_nxt  = fpl_pkg::FPL_SUP_WAIT;
					wait_nxt = 32'h0;
				end
			end
			fpl_pkg::FPL_SUP_WAIT: begin
				wait_nxt = wait_r + 32'h1;
				if (!ctrl_r[`FPL_CTRL_SUPPLY_ON]) begin
					sup_nxt = fpl_pkg::FPL_SUP_IDLE;
				end else if (good_d_r) begin
					sup_nxt = fpl_pkg::FPL_SUP_RUN;
				end else if (wait_r >= GOOD_WAIT_CYC - 1) begin
					sup_nxt    = fpl_pkg::FPL_SUP_FAULT;
					pfault_nxt = 1'b1;
				end
			end
			fpl_pkg::FPL_SUP_FAULT: begin
				if (!ctrl_r[`FPL_CTRL_SUPPLY_ON]) begin
					sup_nxt = fpl_pkg::FPL_SUP_IDLE;
				end else if (good_d_r) begin
					pfault_nxt = 1'b0;
					sup_nxt    = fpl_pkg::FPL_SUP_WAIT;
					wait_nxt   = 32'h0;
				end
			end
			fpl_pkg::FPL_SUP_RUN: begin
				sysrst_nxt = 1'b0;
				if (!ctrl_r[`FPL_CTRL_SUPPLY_ON] || !good_d_r) begin
					sysrst_nxt = 1'b1;
					sup_nxt    = fpl_pkg::FPL_SUP_IDLE;
				end
			end
			default: sup_nxt = fpl_pkg::FPL_SUP_IDLE;
		endcase
		if (!ctrl_r[`FPL_CTRL_SUPPLY_ON]) begin
			pfault_nxt = 1'b0;
		end
	end

	// ****************************************************************
	// Power LED pattern
	// ****************************************************************
	assign pst = fpl_pkg::fpl_pstate_e'(ctrl_r[`FPL_CTRL_STATE_HI:`FPL_CTRL_STATE_LO]);

	// Pick the pattern from state, standby, power-good and request.
	always_comb begin
		pat = fpl_pkg::FPL_LED_DARK;
		case (pst)
			fpl_pkg::FPL_PST_ON: begin
				if (stby_d_r && good_d_r) begin
					pat = fpl_pkg::FPL_LED_SOLID;
				end else if (stby_d_r) begin
					pat = fpl_pkg::FPL_LED_FAST;
				end
			end
			fpl_pkg::FPL_PST_SLEEP: begin
				if (stby_d_r && good_d_r && ctrl_r[`FPL_CTRL_SUPPLY_ON]) begin
					pat = fpl_pkg::FPL_LED_SLOW;
				end
			end
			default: pat = fpl_pkg::FPL_LED_DARK;
		endcase
		case (pat)
			fpl_pkg::FPL_LED_SOLID: pled_nxt = 1'b1;
			fpl_pkg::FPL_LED_SLOW:  pled_nxt = slow_ph;
			fpl_pkg::FPL_LED_FAST:  pled_nxt = fast_ph;
			default:                pled_nxt = 1'b0;
		endcase
	end

	// ****************************************************************
	// State registers
	// ****************************************************************

	// Register all state and outputs.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r    <= `FPL_CTRL_RST_VAL;
			imask_r   <= `FPL_IRQ_MASK_RST;
			ist_r     <= '0;
			prdata_r  <= 32'h0;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			good_d_r  <= 1'b0;
			stby_d_r  <= 1'b0;
			sup_r     <= fpl_pkg::FPL_SUP_IDLE;
			wait_r    <= 32'h0;
			pfault_r  <= 1'b0;
			sysrst_r  <= 1'b1;
			pled_r    <= 1'b0;
			pled_n_r  <= 1'b1;
			fled_n_r  <= 1'b1;
			irq_r     <= 1'b0;
			sw_r      <= 4'h0;
		end else begin
			ctrl_r    <= ctrl_nxt;
			imask_r   <= imask_nxt;
			ist_r     <= ist_nxt;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			good_d_r  <= supply_good_input;
			stby_d_r  <= standby_present;
			sup_r     <= sup_nxt;
			wait_r    <= wait_nxt;
			pfault_r  <= pfault_nxt;
			sysrst_r  <= sysrst_nxt;
			pled_r    <= pled_nxt;
			pled_n_r  <= ~pled_nxt;
			fled_n_r  <= ~(pfault_nxt | ctrl_nxt[`FPL_CTRL_FAN_FAIL]);
			irq_r     <= |(ist_nxt & imask_nxt);
			sw_r      <= ctrl_nxt[`FPL_CTRL_SW_NMI:`FPL_CTRL_SW_POWER];
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign prdata                   = prdata_r;
	assign pready                   = pready_r;
	assign pslverr                  = pslverr_r;
	assign supply_on_request        = ctrl_r[`FPL_CTRL_SUPPLY_ON];
	assign system_reset             = sysrst_r;
	assign irq                      = irq_r;
	assign power_led_n              = pled_n_r;
	assign system_fault_indicator_n = fled_n_r;
	// Open collector: drive low only while the switch is pressed.
	assign sw_power_o               = 1'b0;
	assign sw_power_oe              = sw_r[0];
	assign sw_sleep_o               = 1'b0;
	assign sw_sleep_oe              = sw_r[1];
	assign sw_reset_o               = 1'b0;
	assign sw_reset_oe              = sw_r[2];
	assign sw_nmi_o                 = 1'b0;
	assign sw_nmi_oe                = sw_r[3];

endmodule

`default_nettype wire

/* File: core/fpl_consts.svh */
/*
 * Constants of the front-panel status controller: register offsets, field
 * positions, reset values and blink timing.
 * Assumes a 100 MHz pclk and 32-bit APB word addressing.
 */
`ifndef FPL_CONSTS_SVH
`define FPL_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define FPL_OFS_CTRL     12'h000
`define FPL_OFS_STATUS   12'h004
`define FPL_OFS_IRQ_STAT 12'h008
`define FPL_OFS_IRQ_MASK 12'h00c
`define FPL_OFS_INPUTS   12'h010

// ****************************************************************
// Control register fields
// ****************************************************************
`define FPL_CTRL_SUPPLY_ON   0
`define FPL_CTRL_STATE_LO    1
`define FPL_CTRL_STATE_HI    2
`define FPL_CTRL_FAN_FAIL    3
`define FPL_CTRL_SW_POWER    4
`define FPL_CTRL_SW_SLEEP    5
`define FPL_CTRL_SW_RESET    6
`define FPL_CTRL_SW_NMI      7
`define FPL_CTRL_RST_VAL     8'h00

// ****************************************************************
// Interrupt status fields
// ****************************************************************
`define FPL_IRQ_GOOD_CHANGE  0
`define FPL_IRQ_AC_LOSS      1
`define FPL_IRQ_FAULT_SET    2
`define FPL_IRQ_WIDTH        3
`define FPL_IRQ_MASK_RST     3'h0

// ****************************************************************
// Timing
// ****************************************************************
`define FPL_CLK_HZ           100000000
`define FPL_SLOW_BLINK_MHZ   1000
`define FPL_FAST_BLINK_MHZ   3300
`define FPL_SLOW_HALF_CYC    ((`FPL_CLK_HZ / 2) / `FPL_SLOW_BLINK_MHZ * 1000)
`define FPL_FAST_HALF_CYC    ((`FPL_CLK_HZ / 2) / `FPL_FAST_BLINK_MHZ * 1000)
`define FPL_GOOD_WAIT_US     500000
`define FPL_GOOD_WAIT_CYC    (`FPL_GOOD_WAIT_US * (`FPL_CLK_HZ / 1000000))

`endif

/* File: core/fpl_pkg.sv */
/*
 * Types shared by the front-panel status controller.
 * Assumes fpl_consts.svh for all numbers.
 */
package fpl_pkg;

	// System power state as set by software.
	typedef enum logic [1:0] {
		FPL_PST_OFF,
		FPL_PST_ON,
		FPL_PST_SLEEP,
		FPL_PST_RSVD
	} fpl_pstate_e;

	// Power LED patterns.
	typedef enum logic [1:0] {
		FPL_LED_DARK,
		FPL_LED_SOLID,
		FPL_LED_SLOW,
		FPL_LED_FAST
	} fpl_led_e;

	// Supervision of the supply-on request.
	typedef enum {
		FPL_SUP_IDLE,
		FPL_SUP_WAIT,
		FPL_SUP_FAULT,
		FPL_SUP_RUN
	} fpl_sup_e;

endpackage

/* File: core/fpl_blink.sv */
/*
 * Square-wave divider producing a toggling phase at a set half period.
 * Assumes a free-running clock and asynchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module fpl_blink #(
	parameter int unsigned HALF_CYC = 50000000
) (
	// Clock and reset.
	input  wire logic pclk,
	input  wire logic presetn,
	// Phase output, about 50 percent duty.
	output var  logic phase
);

	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic        ph_r;
	logic        ph_nxt;

	// Count to the half period, then flip the phase.
	always_comb begin
		cnt_nxt = cnt_r + 32'h1;
		ph_nxt  = ph_r;
		if (cnt_r >= HALF_CYC - 1) begin
			cnt_nxt = 32'h0;
			ph_nxt  = ~ph_r;
		end
	end

	// Register the divider.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 32'h0;
			ph_r  <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			ph_r  <= ph_nxt;
		end
	end

	assign phase = ph_r;

endmodule

`default_nettype wire

/* File: verification/fpl_supply_model.sv */
/*
 * Behavioural far side: supply rails, board switch logic and backplane fault LEDs.
 * Assumes the bench sets rise delay, standby presence and a dead-supply mode.
 */
`timescale 1ns/1ps
`default_nettype none

module fpl_supply_model (
	// Clock and bench controls.
	input  wire logic       pclk,
	input  wire logic       stby_en,
	input  wire logic       dead,
	input  wire logic [7:0] rise,
	// Supply pins.
	input  wire logic       supply_on_request,
	output var  logic       standby_present,
	output var  logic       supply_good_input,
	// Switch pins as the board sees them, high while pulled low.
	input  wire logic       sw_power_pull,
	input  wire logic       sw_nmi_pull,
	output var  logic       board_power,
	output var  logic       board_nmi,
	// Backplane stand-in.
	input  wire logic [3:0] drive_bad,
	output var  logic [3:0] drive_fault_n
);
	// Scaled stand-in for the one-second startup flash.
	localparam int FLASH_CYC = 100;

	bit       pwr_on;
	bit       pwr_pull_d;
	bit [7:0] flash;

	// A power press toggles board power; an NMI press raises the board NMI.
	always @(posedge pclk) begin
		pwr_pull_d <= sw_power_pull;
		if (sw_power_pull && !pwr_pull_d) begin
			pwr_on <= ~pwr_on;
		end
		board_nmi <= sw_nmi_pull;
	end
	assign board_power = pwr_on;

	// Fault LEDs, active low, one per slot: all lit for the flash after standby
	// appears, then each shows its own slot; the yellow half of each indicator.
	always @(posedge pclk) begin
		if (!stby_en) begin
			flash <= 8'h0;
		end else if (flash < FLASH_CYC) begin
			flash <= flash + 8'h1;
		end
		drive_fault_n <= !stby_en ? 4'hf : (flash < FLASH_CYC) ? 4'h0 : ~drive_bad;
	end

	// ****************************************************************
	// Power-good answer
	// ****************************************************************
	int unsigned dly = 0;

	assign standby_present = stby_en;

	// Good rises a set delay after the request and drops at once without it.
	always @(posedge pclk) begin
		if (!supply_on_request || dead || !stby_en) begin
			supply_good_input <= 1'b0;
			dly <= 0;
		end else if (dly < rise) begin
			dly <= dly + 1;
		end else begin
			supply_good_input <= 1'b1;
		end
	end
endmodule

`default_nettype wire

/* File: verification/fpl_ctrl_chk.sv */
/*
 * Port checker for the front-panel controller, bound to every instance.
 * Assumes one pclk domain and an active-low asynchronous presetn.
 */
`timescale 1ns/1ps
`default_nettype none

module fpl_ctrl_chk (
	// Clock, reset and APB.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic pready,
	input wire logic pslverr,
	// Supply, reset and panel pins.
	input wire logic standby_present,
	input wire logic supply_good_input,
	input wire logic supply_on_request,
	input wire logic system_reset,
	input wire logic power_led_n,
	input wire logic sw_power_o,
	input wire logic sw_sleep_o,
	input wire logic sw_reset_o,
	input wire logic sw_nmi_o,
	input wire logic sw_power_oe
);
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_pready_one_wait: assert property ($rose(psel && penable) |=> pready)
		else $error("pready missing one cycle after access");
	a_pready_pulse: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_slverr_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_dark_no_standby: assert property (!standby_present [*3] |-> power_led_n)
		else $error("power LED lit without standby");
	a_release_after_good: assert property ($fell(system_reset) |-> supply_on_request && supply_good_input)
		else $error("system reset released without power good");
	a_ac_loss_reset: assert property ($fell(supply_good_input) && supply_on_request && !system_reset
		|-> ##[1:3] system_reset)
		else $error("no system reset after power good loss");
	a_switch_low_true: assert property (!(sw_power_o || sw_sleep_o || sw_reset_o || sw_nmi_o))
		else $error("switch output drives high");
	a_oe_by_write: assert property ($changed(sw_power_oe) |-> $past(pwrite && pready) || $past(pwrite && pready, 2))
		else $error("power switch output changed without a write");
endmodule

bind fpl_ctrl fpl_ctrl_chk chk_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pready(pready), .pslverr(pslverr), .standby_present(standby_present),
	.supply_good_input(supply_good_input), .supply_on_request(supply_on_request),
	.system_reset(system_reset), .power_led_n(power_led_n), .sw_power_o(sw_power_o),
	.sw_sleep_o(sw_sleep_o), .sw_reset_o(sw_reset_o), .sw_nmi_o(sw_nmi_o), .sw_power_oe(sw_power_oe)
);

`default_nettype wire

/* File: verification/tb_top.sv */
/*
 * Self-checking bench for the front-panel controller with a supply partner.
 * Assumes shortened blink and fault-wait counts of 20, 6 and 50 cycles.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fpl_consts.svh"

module tb_top;
	// ****************************************************************
	// Signals and instances
	// ****************************************************************
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic        standby_present, supply_good_input, supply_on_request, system_reset;
	logic        power_led_n, system_fault_indicator_n, stby_en, dead, sb, rq, bp, bn;
	logic [3:0]  sw_o, sw_oe, dfn;
	logic [7:0]  rise;
	logic [1:0]  s;
	int          fails, compares, seed, n, cyc;

	fpl_ctrl #(.SLOW_HALF_CYC(20), .FAST_HALF_CYC(6), .GOOD_WAIT_CYC(50)) fpl_ctrl_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.standby_present(standby_present), .supply_good_input(supply_good_input),
		.supply_on_request(supply_on_request), .system_reset(system_reset), .irq(irq),
		.power_led_n(power_led_n), .system_fault_indicator_n(system_fault_indicator_n),
		.sw_power_o(sw_o[0]), .sw_power_oe(sw_oe[0]), .sw_sleep_o(sw_o[1]), .sw_sleep_oe(sw_oe[1]),
		.sw_reset_o(sw_o[2]), .sw_reset_oe(sw_oe[2]), .sw_nmi_o(sw_o[3]), .sw_nmi_oe(sw_oe[3]));
	fpl_supply_model fpl_supply_model_i (.pclk(pclk), .stby_en(stby_en), .dead(dead), .rise(rise),
		.supply_on_request(supply_on_request), .standby_present(standby_present),
		.supply_good_input(supply_good_input), .sw_power_pull(sw_oe[0]), .sw_nmi_pull(sw_oe[3]),
		.board_power(bp), .board_nmi(bn), .drive_bad(4'h5), .drive_fault_n(dfn));

	// Free-running clock and a cycle ceiling against hangs.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, g);
		end
	endtask

	// One APB transfer, held until pready is sampled high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 20) begin
			@(posedge pclk);
			k++;
		end
		chk("pready", 32'h1, {31'h0, pready});
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pat(input fpl_pkg::fpl_led_e x);
		apb(1'b0, `FPL_OFS_STATUS, 32'h0);
		chk("pattern", {30'h0, x}, {30'h0, q[1:0]});
	endtask

	// Waits for the system reset to drop, bounded.
	task automatic wait_run();
		n = 0;
		while (system_reset !== 1'b0 && n < 200) begin
			@(posedge pclk);
			n++;
		end
	endtask

	// Measures one full half period of the power LED; the first change may come
	// from the pattern switch, so only the gap between the later two is counted.
	task automatic halfp();
		logic v;
		repeat (3) begin
			v = power_led_n;
			n = 0;
			while (power_led_n === v && n < 200) begin
				@(posedge pclk);
				n++;
			end
		end
	endtask

	function automatic fpl_pkg::fpl_led_e exp_pat(input logic [1:0] st, input logic b, input logic g, input logic r);
		if (st == 2'h1 && b)
			return g ? fpl_pkg::FPL_LED_SOLID : fpl_pkg::FPL_LED_FAST;
		if (st == 2'h2 && b && g && r)
			return fpl_pkg::FPL_LED_SLOW;
		return fpl_pkg::FPL_LED_DARK;
	endfunction

	task automatic give_verdict();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{psel, penable, pwrite, presetn, dead} = '0;
		{paddr, pwdata} = '0;
		{stby_en, rise, seed} = {1'b1, 8'h03, 32'd6080};
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		chk("power_led_n", 32'h1, {31'h0, power_led_n});
		apb(1'b0, `FPL_OFS_IRQ_MASK, 32'h0);
		chk("irq_mask", 32'h0, q);
		apb(1'b0, 12'h014, 32'h0);
		chk("unmapped", 32'h1, {31'h0, e});
		chk("drive flash", 32'h0, {28'h0, dfn});
		$display("test reset done");
		apb(1'b1, `FPL_OFS_CTRL, 32'h3);
		wait_run();
		chk("system_reset", 32'h0, {31'h0, system_reset});
		pat(fpl_pkg::FPL_LED_SOLID);
		apb(1'b1, `FPL_OFS_CTRL, 32'hb);
		repeat (3) @(posedge pclk);
		chk("fault_n fan", 32'h0, {31'h0, system_fault_indicator_n});
		apb(1'b1, `FPL_OFS_CTRL, 32'h3);
		$display("test power on done");
		dead <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("ac loss reset", 32'h1, {31'h0, system_reset});
		halfp();
		chk("fast half", 32'd6, n);
		repeat (60) @(posedge pclk);
		chk("fault_n", 32'h0, {31'h0, system_fault_indicator_n});
		apb(1'b0, `FPL_OFS_IRQ_STAT, 32'h0);
		chk("irq_stat", 32'h7, q & 32'h7);
		chk("irq masked", 32'h0, {31'h0, irq});
		apb(1'b1, `FPL_OFS_IRQ_MASK, 32'h7);
		repeat (2) @(posedge pclk);
		chk("irq", 32'h1, {31'h0, irq});
		apb(1'b1, `FPL_OFS_IRQ_STAT, 32'h7);
		repeat (2) @(posedge pclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		dead <= 1'b0;
		wait_run();
		chk("fault_n clear", 32'h1, {31'h0, system_fault_indicator_n});
		chk("irq good", 32'h1, {31'h0, irq});
		apb(1'b1, `FPL_OFS_IRQ_STAT, 32'h7);
		chk("drive fault", 32'ha, {28'h0, dfn});
		$display("test supply fault done");
		apb(1'b1, `FPL_OFS_CTRL, 32'h5);
		halfp();
		chk("slow half", 32'd20, n);
		pat(fpl_pkg::FPL_LED_SLOW);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, `FPL_OFS_CTRL, 32'h10 << i);
			repeat (2) @(posedge pclk);
			chk("sw_oe", 32'h1 << i, {28'h0, sw_oe});
			chk("sw_o", 32'h0, {28'h0, sw_o});
			chk("board_power", 32'h1, {31'h0, bp});
			chk("board_nmi", {31'h0, i == 3}, {31'h0, bn});
		end
		rise <= 8'd40;
		apb(1'b1, `FPL_OFS_CTRL, 32'h3);
		repeat (60) @(posedge pclk);
		chk("slow supply", 32'h1, {31'h0, system_fault_indicator_n});
		$display("test sleep and switches done");
		repeat (8) begin
			s = 2'($random(seed));
			{sb, rq} = 2'($random(seed));
			stby_en <= sb;
			rise <= 8'($random(seed)) & 8'h0f;
			apb(1'b1, `FPL_OFS_CTRL, {24'h0, 4'($random(seed)), 1'b0, s, rq});
			repeat (40) @(posedge pclk);
			pat(exp_pat(s, sb, sb && rq, rq));
			if (exp_pat(s, sb, sb && rq, rq) == fpl_pkg::FPL_LED_DARK)
				chk("power_led_n dark", 32'h1, {31'h0, power_led_n});
			apb(1'b0, `FPL_OFS_INPUTS, 32'h0);
			chk("inputs", {30'h0, sb && rq, sb}, q);
		end
		$display("test random done");
		give_verdict();
	end
endmodule

`default_nettype wire
